// File: hdl/tpg_timer.sv
// Gated-mode PWM/capture/compare timer with an AXI4-Lite register slave.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module tpg_timer
  import tpg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_irq
);

  tpg_state_t s;
  tpg_state_t next_s;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [7:0] wbyte;
  logic [6:0] presc_lim;
  logic active;
  logic sel_edge;
  logic gate_drop;
  logic count_ok;
  logic tick;
  logic [31:0] rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // Decode and input conditioning

  // Handshakes complete while our ready flop is high and the master still holds valid
  assign wr_fire = s.awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = s.arready && s_axi_arvalid;
  assign wr_ofs = 8'(s_axi_awaddr);
  assign rd_ofs = 8'(s_axi_araddr);
  assign wbyte = s_axi_wdata[7:0];
  assign wr_hit = (wr_ofs <= PWM_LO_OFS) && (wr_ofs[1:0] == 2'h0);
  assign rd_hit = (rd_ofs <= PWM_LO_OFS) && (rd_ofs[1:0] == 2'h0);

  // Only the second sync stage and its delayed copy feed the edge logic
  assign active = (s.in_s2 == s.pol);
  assign sel_edge = (s.in_s2 != s.in_d) && active;
  assign gate_drop = (s.in_d == s.pol) && !active;

  // Divide-by 2^n prescaler; gated mode also freezes it while the gate is off
  assign presc_lim = 7'((8'h01 << s.pre_exp) - 8'h01);
  assign count_ok = (s.mode != MODE_GATED) || active;
  assign tick = (s.st == ST_RUN) && count_ok && (s.presc == presc_lim);

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux

  // Count low returns the latched byte only while enabled
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_ofs)
      CTRL_OFS: begin
        rd_data[CTRL_EN_BIT] = s.en;
        rd_data[CTRL_MODE_LSB +: 3] = s.mode;
        rd_data[CTRL_PRE_LSB +: 3] = s.pre_exp;
        rd_data[CTRL_POL_BIT] = s.pol;
        rd_data[CTRL_RUN_BIT] = (s.st == ST_RUN);
      end
      CNT_HI_OFS: rd_data[7:0] = s.cnt[15:8];
      CNT_LO_OFS: rd_data[7:0] = s.en ? s.read_hold : s.cnt[7:0];
      RLD_HI_OFS: rd_data[7:0] = s.reload[15:8];
      RLD_LO_OFS: rd_data[7:0] = s.reload[7:0];
      PWM_HI_OFS: rd_data[7:0] = s.pwm[15:8];
      PWM_LO_OFS: rd_data[7:0] = s.pwm[7:0];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.irq = 1'b0; // Events never stretch beyond one cycle
    next_s.in_s1 = timer_in;
    next_s.in_s2 = s.in_s1;
    next_s.in_d = s.in_s2;

    // Write channel: take address and data together, answer one cycle later
    next_s.awready = 1'b0;
    next_s.wready = 1'b0;
    if (!s.bvalid && !s.awready && s_axi_awvalid && s_axi_wvalid) begin
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel: data registered at the address handshake
    next_s.arready = 1'b0;
    if (!s.rvalid && !s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b1;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
      next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      // Latch only touches the holding byte, never the counter
      if (rd_ofs == CNT_HI_OFS && s.en) begin
        next_s.read_hold = s.cnt[7:0];
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // Run state; capture/compare waits for its first edge
    case (s.st)
      ST_OFF: begin
        if (s.en) begin
          next_s.st = (s.mode == MODE_CAPCMP) ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (sel_edge) begin
          next_s.st = ST_RUN; // No interrupt on the starting edge
        end
      end
      ST_RUN: next_s.st = ST_RUN;
      default: next_s.st = ST_OFF;
    endcase
    if (!s.en) begin
      next_s.st = ST_OFF;
    end

    // Prescaler
    if (s.st != ST_RUN) begin
      next_s.presc = 7'h00;
    end else if (count_ok) begin
      next_s.presc = tick ? 7'h00 : 7'(s.presc + 7'h01);
    end

    // Idle output sits at the polarity level so the first period starts right
    if (!s.en) begin
      next_s.out = s.pol;
    end else if (s.st == ST_RUN) begin
      case (s.mode)
        MODE_PWM: begin
          if (tick) begin
            if (s.cnt == s.reload) begin
              next_s.cnt = CNT_RESTART; // Start count only mattered once
              next_s.irq = 1'b1;
              next_s.out = s.pol;
            end else begin
              next_s.cnt = 16'(s.cnt + 16'h0001);
              if (s.cnt == s.pwm) begin
                next_s.out = !s.pol;
              end
            end
          end
        end
        MODE_CAPTURE: begin
          if (sel_edge) begin
            next_s.pwm = s.cnt;
            next_s.irq = 1'b1;
          end
          if (tick) begin
            if (s.cnt == s.reload) begin
              next_s.irq = 1'b1;
            end
            next_s.cnt = 16'(s.cnt + 16'h0001);
          end
        end
        MODE_COMPARE: begin
          if (tick) begin
            if (s.cnt == s.reload) begin
              next_s.irq = 1'b1;
              next_s.out = !s.out;
            end
            // Natural 16-bit rollover gives the FFFFH to 0000H wrap
            next_s.cnt = 16'(s.cnt + 16'h0001);
          end
        end
        MODE_GATED: begin
          if (gate_drop) begin
            next_s.irq = 1'b1;
          end
          if (tick) begin
            if (s.cnt == s.reload) begin
              next_s.cnt = CNT_RESTART;
              next_s.irq = 1'b1;
              next_s.out = !s.out;
            end else begin
              next_s.cnt = 16'(s.cnt + 16'h0001);
            end
          end
        end
        MODE_CAPCMP: begin
          // An edge wins over a compare hit in the same cycle
          if (sel_edge) begin
            next_s.pwm = s.cnt;
            next_s.cnt = CNT_RESTART;
            next_s.irq = 1'b1;
          end else if (tick) begin
            if (s.cnt == s.reload) begin
              next_s.cnt = CNT_RESTART;
              next_s.irq = 1'b1;
            end else begin
              next_s.cnt = 16'(s.cnt + 16'h0001);
            end
          end
        end
        default: next_s.cnt = s.cnt;
      endcase
    end

    // Register writes; a byte written mid-count lands on the next edge
    // A byte register whose lane-0 strobe is low keeps its value, as the bus expects
    if (wr_fire && (s_axi_wstrb[0] || wr_ofs == CTRL_OFS)) begin
      case (wr_ofs)
        CTRL_OFS: begin
          next_s.en = s_axi_wdata[CTRL_EN_BIT];
          next_s.mode = s_axi_wdata[CTRL_MODE_LSB +: 3];
          next_s.pre_exp = s_axi_wdata[CTRL_PRE_LSB +: 3];
          next_s.pol = s_axi_wdata[CTRL_POL_BIT];
        end
        CNT_HI_OFS: next_s.cnt[15:8] = wbyte;
        CNT_LO_OFS: next_s.cnt[7:0] = wbyte;
        RLD_HI_OFS: next_s.reload_hold = wbyte;
        // Both reload bytes change together so a period is never half-updated
        RLD_LO_OFS: next_s.reload = {s.reload_hold, wbyte};
        PWM_HI_OFS: next_s.pwm[15:8] = wbyte;
        PWM_LO_OFS: next_s.pwm[7:0] = wbyte;
        default: next_s.en = s.en;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= ST_OFF;
      s.mode <= MODE_RST;
      s.pre_exp <= PRE_RST;
      s.cnt <= CNT_RST;
      s.reload <= RLD_RST;
      s.reload_hold <= RLD_RST[15:8];
      s.pwm <= PWM_RST;
      s.bresp <= RESP_OKAY;
      s.rresp <= RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timer_out = s.out;
  assign timer_irq = s.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pwm_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.mode == MODE_PWM && tick && s.cnt == s.reload && !wr_fire
    |=> s.cnt == CNT_RESTART && timer_irq && timer_out == s.pol)
    else $error("pwm restart wrong");

  a_pwm_match_out: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.mode == MODE_PWM && tick && s.cnt == s.pwm && s.cnt != s.reload && !wr_fire
    |=> timer_out == !$past(s.pol) && !timer_irq)
    else $error("pwm match output wrong");

  a_cap_store: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.st == ST_RUN && s.mode == MODE_CAPTURE && sel_edge && !wr_fire
    |=> s.pwm == $past(s.cnt) && timer_irq)
    else $error("capture not stored");

  a_cap_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.mode == MODE_CAPTURE && tick && s.cnt == s.reload && !wr_fire
    |=> timer_irq && s.cnt == 16'($past(s.cnt) + 16'h0001))
    else $error("capture reload wrong");

  a_cmp_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.mode == MODE_COMPARE && tick && s.cnt == CNT_TOP && !wr_fire
    |=> s.cnt == CNT_WRAP)
    else $error("compare wrap wrong");

  a_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.mode == MODE_GATED && !active && !wr_fire
    |=> $stable(s.cnt))
    else $error("gated count moved");

  a_gate_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.st == ST_RUN && s.mode == MODE_GATED && gate_drop && !wr_fire
    |=> timer_irq ##1 !timer_irq)
    else $error("gate drop irq missing");

  a_cc_first: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.st == ST_WAIT && sel_edge && !wr_fire
    |=> !timer_irq && s.st == ST_RUN && $stable(s.cnt))
    else $error("first edge mishandled");

  a_cc_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    s.en && s.st == ST_RUN && s.mode == MODE_CAPCMP && sel_edge && !wr_fire
    |=> s.cnt == CNT_RESTART && s.pwm == $past(s.cnt) && timer_irq)
    else $error("capcmp capture wrong");

  a_read_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_ofs == CNT_HI_OFS && s.en
    |=> s.read_hold == $past(s.cnt[7:0]))
    else $error("count low not latched");

  a_presc_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && s.mode != MODE_GATED && s.pre_exp == 3'h1 && !wr_fire
    |=> !tick ##1 (tick || !s.en || s.st != ST_RUN || $changed(s.pre_exp)))
    else $error("prescale spacing wrong");

endmodule

// File: shared/tpg_pkg.sv
// Shared constants and types for the gated-mode PWM/capture timer.
package tpg_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CNT_HI_OFS = 8'h04;
  localparam logic [7:0] CNT_LO_OFS = 8'h08;
  localparam logic [7:0] RLD_HI_OFS = 8'h0C;
  localparam logic [7:0] RLD_LO_OFS = 8'h10;
  localparam logic [7:0] PWM_HI_OFS = 8'h14;
  localparam logic [7:0] PWM_LO_OFS = 8'h18;
  // Control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_POL_BIT = 7;
  localparam int CTRL_RUN_BIT = 8;
  // Mode encodings held in the control register
  localparam logic [2:0] MODE_PWM = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h1;
  localparam logic [2:0] MODE_COMPARE = 3'h2;
  localparam logic [2:0] MODE_GATED = 3'h3;
  localparam logic [2:0] MODE_CAPCMP = 3'h4;
  // Counter values and reset values
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] CNT_WRAP = 16'h0000;
  localparam logic [15:0] RLD_RST = 16'hFFFF;
  localparam logic [15:0] PWM_RST = 16'h0000;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Counter run state
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } tpg_st_t;
  // Whole state of the timer in one register
  typedef struct packed {
    logic en;
    logic [2:0] mode;
    logic [2:0] pre_exp;
    logic pol;
    tpg_st_t st;
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [7:0] reload_hold;
    logic [15:0] pwm;
    logic [7:0] read_hold;
    logic [6:0] presc;
    logic out;
    logic irq;
    logic in_s1;
    logic in_s2;
    logic in_d;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tpg_state_t;
endpackage

// File: tb/testbench.sv
// Self-checking bench for the timer: register bus, PWM, capture, compare, gated modes.
`timescale 1ns/1ns
module testbench;
  import tpg_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic want_level, timer_in, timer_out, timer_irq, prev_out, prev_irq;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int irq_q[$];
  int tog_q[$];

  tpg_timer #(.ADDR_W(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_in, .timer_out, .timer_irq);
  tpg_pin_model pins (.aclk, .aresetn, .want_level, .timer_in);

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cycle stamps of interrupt pulses and output changes, taken from sampled values
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (timer_irq === 1'b1)
      irq_q.push_back(cyc);
    if (aresetn === 1'b1 && timer_out !== prev_out)
      tog_q.push_back(cyc);
    if (timer_irq === 1'b1 && prev_irq === 1'b1)
      chk(1'b1, 1'b0, "interrupt wider than one cycle");
    prev_out <= timer_out;
    prev_irq <= timer_irq;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bus write: both channels offered together, each dropped on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er}, "read response");
  endtask

  // Coherent count read: high byte first, which freezes the low byte while enabled
  task automatic rdcnt(output logic [15:0] v);
    logic [31:0] h, l;
    rd(CNT_HI_OFS, h);
    rd(CNT_LO_OFS, l);
    v = {h[7:0], l[7:0]};
  endtask

  // Disable, set mode and polarity, load count, match and reload, then enable
  task automatic cfg(input logic [2:0] m, input logic p, input logic [15:0] st, rl, pw,
    input logic [2:0] pe = 3'h0);
    logic [31:0] c;
    c = (32'(m) << CTRL_MODE_LSB) | (32'(p) << CTRL_POL_BIT) | (32'(pe) << CTRL_PRE_LSB);
    wr(CTRL_OFS, c);
    wr(CNT_HI_OFS, 32'(st[15:8]));
    wr(CNT_LO_OFS, 32'(st[7:0]));
    wr(PWM_HI_OFS, 32'(pw[15:8]));
    wr(PWM_LO_OFS, 32'(pw[7:0]));
    wr(RLD_HI_OFS, 32'(rl[15:8]));
    wr(RLD_LO_OFS, 32'(rl[7:0]));
    wr(CTRL_OFS, c | 32'h1);
    irq_q.delete();
    tog_q.delete();
  endtask

  task automatic wait_irq(input int n, input int lim);
    repeat (lim) begin
      if (irq_q.size() >= n)
        break;
      @(posedge aclk);
    end
    chk(irq_q.size() >= n, 1'b1, "interrupt count");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, read-only run bit, unmapped places, live count reads while stopped
  task automatic t_regs;
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), d);
      chk(d, (i == 3 || i == 4) ? 32'hFF : 32'h0, "reset value");
    end
    wr(CTRL_OFS, 32'h100);
    rd(CTRL_OFS, d);
    chk(d, 32'h0, "run bit is read-only");
    rd(8'h1C, d, RESP_SLVERR);
    chk(d, 32'h0, "unmapped read data");
    wr(8'h02, 32'h1, RESP_SLVERR);
    rd(CTRL_OFS, d);
    chk(d, 32'h0, "misaligned write took effect");
    wr(CNT_HI_OFS, 32'h12);
    wr(CNT_LO_OFS, 32'h34);
    rd(CNT_LO_OFS, d);
    chk(d, 32'h34, "stopped low byte");
    rd(CNT_HI_OFS, d);
    chk(d, 32'h12, "stopped high byte");
    wr(PWM_LO_OFS, 32'h55);
    s_axi_wstrb <= 4'h0;
    wr(PWM_LO_OFS, 32'hAA);
    s_axi_wstrb <= 4'hF;
    rd(PWM_LO_OFS, d);
    chk(d, 32'h55, "masked byte write");
  endtask

  // Prescaled PWM: reload 4 and match 2 give a period of 4 ticks, each 2^e clocks
  task automatic t_pre(input logic [2:0] e);
    cfg(MODE_PWM, 1'b1, 16'h0001, 16'h0004, 16'h0002, e);
    wait_irq(2, 40 << e);
    chk(irq_q[1] - irq_q[0], 4 << e, "prescaled period");
    chk(irq_q[0] - tog_q[0], 2 << e, "prescaled match");
  endtask

  // Start count 5 shapes only the first period; later ones run 1..12
  task automatic t_pwm(input logic p);
    cfg(MODE_PWM, p, 16'h0005, 16'h000C, 16'h0008);
    chk(timer_out, p, "pwm start level");
    wait_irq(3, 80);
    chk(irq_q[0] - tog_q[0], 4, "match to reload");
    chk(tog_q[1], irq_q[0], "output back at restart");
    chk(tog_q[2] - irq_q[0], 8, "restart to match");
    chk(irq_q[1] - irq_q[0], 12, "pwm period");
    chk(timer_out, p, "level after restart");
  endtask

  // Rising edge captures; the reload interrupt comes 64 minus the capture later
  task automatic t_cap;
    logic [31:0] h, l;
    cfg(MODE_CAPTURE, 1'b1, 16'h0001, 16'h0040, 16'h0000);
    repeat (20) @(posedge aclk);
    want_level <= 1'b1;
    wait_irq(2, 120);
    rd(PWM_HI_OFS, h);
    rd(PWM_LO_OFS, l);
    chk({h[7:0], l[7:0]} + (irq_q[1] - irq_q[0]), 32'h40, "capture vs reload");
  endtask

  // Compare must wrap through FFFFH to reach 5, and must not restart there
  task automatic t_cmp;
    logic [15:0] v;
    cfg(MODE_COMPARE, 1'b0, 16'hFFFC, 16'h0005, 16'h0000);
    wait_irq(1, 40);
    chk(timer_out, 1'b1, "compare toggle");
    rdcnt(v);
    chk(v > 16'h0005 && v < 16'h0020, 1'b1, "count kept running");
  endtask

  // Active-low gate: frozen while high, reloads every 16 while low
  task automatic t_gate;
    logic [15:0] v, w;
    cfg(MODE_GATED, 1'b0, 16'h0001, 16'h0010, 16'h0000);
    repeat (20) @(posedge aclk);
    rdcnt(v);
    chk(v, 16'h0001, "gate closed count");
    want_level <= 1'b0;
    wait_irq(2, 80);
    chk(irq_q[1] - irq_q[0], 16, "gated period");
    chk(tog_q[0], irq_q[0], "toggle at reload");
    want_level <= 1'b1;
    wait_irq(3, 20);
    rdcnt(v);
    rdcnt(w);
    chk(w, v, "count frozen after gate drop");
  endtask

  // First rising edge only starts, second captures and restarts, then compare at 48
  task automatic t_capcmp;
    logic [31:0] h, l;
    logic [15:0] v;
    want_level <= 1'b0;
    cfg(MODE_CAPCMP, 1'b1, 16'h0001, 16'h0030, 16'h0000);
    repeat (20) @(posedge aclk);
    rdcnt(v);
    chk(v, 16'h0001, "waiting for first edge");
    want_level <= 1'b1;
    repeat (30) @(posedge aclk);
    chk(irq_q.size(), 0, "first edge interrupt");
    want_level <= 1'b0;
    repeat (10) @(posedge aclk);
    want_level <= 1'b1;
    wait_irq(2, 120);
    chk(irq_q[1] - irq_q[0], 48, "restart then compare");
    rd(PWM_HI_OFS, h);
    rd(PWM_LO_OFS, l);
    chk({h[7:0], l[7:0]} inside {16'd40, 16'd41}, 1'b1, "edge spacing captured");
  endtask

  // Held low byte across a long gap; the count advances exactly with elapsed cycles
  task automatic t_latch;
    logic [31:0] h, l;
    logic [15:0] v;
    int t1, t2;
    cfg(MODE_COMPARE, 1'b0, 16'h0010, 16'h8000, 16'h0000);
    t1 = cyc;
    rd(CNT_HI_OFS, h);
    repeat (300) @(posedge aclk);
    rd(CNT_LO_OFS, l);
    t2 = cyc;
    rdcnt(v);
    chk(v - {h[7:0], l[7:0]}, 16'(t2 - t1), "held count");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence after 12 cycles of reset
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, want_level} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_pwm(1'b1);
    t_pwm(1'b0);
    t_cap();
    t_cmp();
    t_gate();
    t_capcmp();
    t_latch();
    t_pre(3'h1);
    t_pre(3'h7);
    complete_run();
  end

  // Watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run();
  end
endmodule

// File: tb/tpg_pin_model.sv
// Pin-side partner: the outside source that drives the timer input pin.
`timescale 1ns/1ns
module tpg_pin_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic want_level,
  output logic timer_in
);
  logic [1:0] hold;
  // Follow the bench's request, but never change faster than a quarter of the clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold <= 2'h0;
      timer_in <= want_level;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (want_level != timer_in) begin
      timer_in <= want_level;
      hold <= 2'h3;
    end
  end
endmodule
